// ===== uspc_port_ctl.sv
// Status and control register and sequencing for one root hub port
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uspc_port_ctl
    import uspc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Controller status
    input wire logic global_configured_flag,
    input wire logic controller_halted,
    input wire logic power_control_capable,
    output logic port_change_detect,
    // Port sensing
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic connect_in,
    input wire logic overcurrent_in,
    input wire logic hs_detected,
    input wire logic port_error_eof2,
    input wire logic transaction_busy,
    // Port control
    output logic port_power_out,
    output logic companion_owns,
    output logic drive_bus_reset,
    output logic drive_resume_k,
    output logic downstream_enable
);
    localparam int TW = $clog2(SETTLE_CYCLES + 1);

    typedef struct packed {
        uspc_state_e st;
        logic owner;
        logic power;
        logic rst_bit;
        logic rst_clr;
        logic hs_seen;
        logic susp;
        logic susp_req;
        logic fr;
        logic oc_chg;
        logic oc_act;
        logic en_chg;
        logic en;
        logic cs_chg;
        logic cs;
        logic cfg_prev;
        logic pcd;
        logic drv_rst;
        logic drv_k;
        logic ds_en;
        logic tmr_load;
        logic [31:0] rdata;
    } uspc_ctl_s;

    uspc_ctl_s q_reg, q_next;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;

    uspc_port_if #(.TW(TW)) pif ();

    uspc_line_mon u_line_mon (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif.mon)
    );

    uspc_timer #(.TW(TW)) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif.tmr)
    );

    assign pif.line_dp = line_dp;
    assign pif.line_dm = line_dm;
    assign pif.tmr_load = q_reg.tmr_load;
    assign pif.tmr_val = TW'(SETTLE_CYCLES);
    assign wr_hit = reg_wr && (reg_addr == PSC_OFS);
    assign rd_hit = reg_rd && (reg_addr == PSC_OFS);

    // Connect, enable, suspend, resume and reset bits already read zero when unpowered, since the state clears them
    always_comb begin
        rd_val = '0;
        rd_val[B_OWNER] = q_reg.owner;
        rd_val[B_POWER] = q_reg.power;
        rd_val[B_LINE_LO+1:B_LINE_LO] = pif.line_state;
        rd_val[B_RST] = q_reg.rst_bit;
        rd_val[B_SUSP] = q_reg.susp;
        rd_val[B_FR] = q_reg.fr;
        rd_val[B_OC_CHG] = q_reg.oc_chg;
        rd_val[B_OC_ACT] = q_reg.oc_act;
        rd_val[B_EN_CHG] = q_reg.en_chg;
        rd_val[B_EN] = q_reg.en;
        rd_val[B_CS_CHG] = q_reg.cs_chg;
        rd_val[B_CS] = q_reg.cs;
    end

    always_comb begin
        q_next = q_reg;
        q_next.pcd = 1'b0;
        q_next.tmr_load = 1'b0;
        q_next.rdata = rd_hit ? rd_val : '0;
        q_next.cfg_prev = global_configured_flag;
        // Ownership
        if (wr_hit && global_configured_flag) begin
            q_next.owner = reg_wdata[B_OWNER];
        end
        if (global_configured_flag && !q_reg.cfg_prev) begin
            q_next.owner = 1'b0;
        end
        if (!global_configured_flag) begin
            q_next.owner = 1'b1;
        end
        // Power switch; without switches the port is always powered
        if (!power_control_capable) begin
            q_next.power = 1'b1;
        end else if (wr_hit) begin
            q_next.power = reg_wdata[B_POWER];
        end
        if (power_control_capable && q_reg.power && overcurrent_in && !q_reg.oc_act) begin
            q_next.power = 1'b0;
        end
        // Over-current; clear first so a same-cycle change wins
        q_next.oc_act = overcurrent_in;
        if (wr_hit && reg_wdata[B_OC_CHG]) begin
            q_next.oc_chg = 1'b0;
        end
        if (overcurrent_in != q_reg.oc_act) begin
            q_next.oc_chg = 1'b1;
        end
        // Connect status
        q_next.cs = q_reg.power && connect_in;
        if (wr_hit && reg_wdata[B_CS_CHG]) begin
            q_next.cs_chg = 1'b0;
        end
        if (q_next.cs != q_reg.cs) begin
            q_next.cs_chg = 1'b1;
        end
        // Enable: software may only clear it
        if (wr_hit && reg_wdata[B_EN_CHG]) begin
            q_next.en_chg = 1'b0;
        end
        if (wr_hit && !reg_wdata[B_EN]) begin
            q_next.en = 1'b0;
        end
        if (q_reg.en && port_error_eof2) begin
            q_next.en = 1'b0;
            q_next.en_chg = 1'b1;
        end
        if (!q_next.cs) begin
            q_next.en = 1'b0;
        end
        // Suspend takes effect only once the bus is quiet
        if (wr_hit && reg_wdata[B_SUSP] && q_reg.en && !q_reg.susp) begin
            q_next.susp_req = 1'b1;
        end
        if (q_reg.susp_req && !transaction_busy) begin
            q_next.susp = 1'b1;
            q_next.susp_req = 1'b0;
        end
        // Resume entry, by software or by remote wake
        if (q_reg.st == PS_IDLE && !q_reg.fr) begin
            if (wr_hit && reg_wdata[B_FR]) begin
                q_next.fr = 1'b1;
                q_next.drv_k = 1'b1;
                q_next.st = PS_RESUME;
            end else if (q_reg.susp && q_reg.en && pif.j_to_k) begin
                q_next.fr = 1'b1;
                q_next.pcd = 1'b1;
                q_next.drv_k = 1'b1;
                q_next.st = PS_RESUME;
            end
        end
        unique case (q_reg.st)
            PS_IDLE: begin
            end
            PS_RESUME: begin
                if (wr_hit && !reg_wdata[B_FR]) begin
                    q_next.drv_k = 1'b0;
                    q_next.tmr_load = 1'b1;
                    q_next.st = PS_RES_END;
                end
            end
            PS_RES_END: begin
                if (pif.tmr_done) begin
                    q_next.fr = 1'b0;
                    q_next.susp = 1'b0;
                    q_next.st = PS_IDLE;
                end
            end
            PS_RESET: begin
                if (hs_detected) begin
                    q_next.hs_seen = 1'b1;
                end
                if (wr_hit && !reg_wdata[B_RST]) begin
                    q_next.rst_clr = 1'b1;
                end
                // A halted controller keeps the bus reset going
                if ((q_reg.rst_clr || (wr_hit && !reg_wdata[B_RST])) && !controller_halted) begin
                    q_next.drv_rst = 1'b0;
                    q_next.tmr_load = 1'b1;
                    q_next.st = PS_RST_END;
                end
            end
            PS_RST_END: begin
                if (pif.tmr_done) begin
                    q_next.rst_bit = 1'b0;
                    q_next.en = q_reg.hs_seen && q_next.cs;
                    q_next.st = PS_IDLE;
                end
            end
            default: begin
                q_next.st = PS_IDLE;
            end
        endcase
        // Reset start overrides suspend, resume and enable
        if (wr_hit && reg_wdata[B_RST] && !q_reg.rst_bit && q_reg.power) begin
            q_next.rst_bit = 1'b1;
            q_next.rst_clr = 1'b0;
            q_next.hs_seen = 1'b0;
            q_next.drv_rst = 1'b1;
            q_next.drv_k = 1'b0;
            q_next.susp = 1'b0;
            q_next.susp_req = 1'b0;
            q_next.fr = 1'b0;
            q_next.en = 1'b0;
            q_next.st = PS_RESET;
        end
        if (!q_next.power) begin
            q_next.rst_bit = 1'b0;
            q_next.rst_clr = 1'b0;
            q_next.susp = 1'b0;
            q_next.susp_req = 1'b0;
            q_next.fr = 1'b0;
            q_next.en_chg = 1'b0;
            q_next.en = 1'b0;
            q_next.cs_chg = 1'b0;
            q_next.cs = 1'b0;
            q_next.drv_rst = 1'b0;
            q_next.drv_k = 1'b0;
            q_next.st = PS_IDLE;
        end
        // Traffic only in the enabled state
        q_next.ds_en = q_next.en && !q_next.susp && !q_next.susp_req;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_reg <= '0;
            q_reg.owner <= PSC_RESET[B_OWNER];
            q_reg.st <= PS_IDLE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign reg_rdata = q_reg.rdata;
    assign port_change_detect = q_reg.pcd;
    assign port_power_out = q_reg.power;
    assign companion_owns = q_reg.owner;
    assign drive_bus_reset = q_reg.drv_rst;
    assign drive_resume_k = q_reg.drv_k;
    assign downstream_enable = q_reg.ds_en;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence rst_start_s;
        wr_hit && reg_wdata[B_RST] && !q_reg.rst_bit && q_reg.power && power_control_capable;
    endsequence

    sequence rst_entered_s;
        q_reg.rst_bit && q_reg.drv_rst && !q_reg.en && !q_reg.susp;
    endsequence

    owner_forced_a: assert property (!global_configured_flag |=> companion_owns)
        else $error("owner not forced while unconfigured");
    owner_clear_a: assert property ($rose(global_configured_flag) |=> !companion_owns)
        else $error("owner not cleared on configured rise");
    reset_start_a: assert property (rst_start_s |=> rst_entered_s)
        else $error("reset sequence did not start");
    reset_hold_a: assert property (q_reg.st == PS_RST_END |-> q_reg.rst_bit ##1 q_reg.rst_bit || q_reg.st == PS_IDLE)
        else $error("reset bit dropped before completion");
    enable_sw_a: assert property (wr_hit && reg_wdata[B_EN] && !q_reg.en && q_reg.st != PS_RST_END |=> !q_reg.en)
        else $error("software enabled the port");
    wake_pcd_a: assert property (q_reg.st == PS_IDLE && q_reg.susp && q_reg.en && pif.j_to_k && !q_reg.fr && !wr_hit && q_next.power |=> port_change_detect && q_reg.fr && drive_resume_k)
        else $error("remote wake not flagged");
    sw_resume_a: assert property (wr_hit && reg_wdata[B_FR] && !reg_wdata[B_RST] && q_reg.st == PS_IDLE && !q_reg.fr && q_next.power |=> !port_change_detect && drive_resume_k)
        else $error("software resume raised change detect");
    conn_chg_a: assert property ($changed(q_reg.cs) && q_reg.power |-> q_reg.cs_chg)
        else $error("connect change missed");
    oc_chg_a: assert property ($changed(q_reg.oc_act) |-> q_reg.oc_chg)
        else $error("over-current change missed");
    unpowered_a: assert property (rd_hit && !q_reg.power |=> (reg_rdata & 32'h0000_01cf) == 32'h0)
        else $error("status bits set while unpowered");
endmodule
`default_nettype wire

// ===== uspc_pkg.sv
// Constants shared by the USB host port status and control block
package uspc_pkg;
    // Register decode and reset value
    localparam logic [7:0] PSC_OFS = 8'h00;
    localparam logic [31:0] PSC_RESET = 32'h0000_2000;
    // Field positions
    localparam int B_CS = 0;
    localparam int B_CS_CHG = 1;
    localparam int B_EN = 2;
    localparam int B_EN_CHG = 3;
    localparam int B_OC_ACT = 4;
    localparam int B_OC_CHG = 5;
    localparam int B_FR = 6;
    localparam int B_SUSP = 7;
    localparam int B_RST = 8;
    localparam int B_LINE_LO = 10;
    localparam int B_POWER = 12;
    localparam int B_OWNER = 13;
    // Line encodings as {D+, D-}
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_J = 2'h2;
    localparam logic [1:0] LINE_K = 2'h1;
    // Settle time after reset or resume ends
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_SETTLE_NS = 2000000;
    localparam int SETTLE_CYC = T_SETTLE_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {PS_IDLE, PS_RESET, PS_RST_END, PS_RESUME, PS_RES_END} uspc_state_e;
endpackage

// ===== uspc_port_if.sv
// Carrier between the port controller, its line monitor and its timer
`timescale 1ns/1ns
`default_nettype none
interface uspc_port_if #(parameter int TW = 20);
    logic line_dp;
    logic line_dm;
    logic [1:0] line_state;
    logic j_to_k;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic tmr_done;
    modport mon (input line_dp, line_dm, output line_state, j_to_k);
    modport tmr (input tmr_load, tmr_val, output tmr_done);
    modport ctl (output line_dp, line_dm, tmr_load, tmr_val, input line_state, j_to_k, tmr_done);
endinterface
`default_nettype wire

// ===== uspc_line_mon.sv
// Samples D+ and D- and flags a J to K transition
`timescale 1ns/1ns
`default_nettype none
module uspc_line_mon
    import uspc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Line side
    uspc_port_if.mon pif
);
    typedef struct packed {
        logic [1:0] line;
        logic jk;
    } uspc_mon_s;
    uspc_mon_s q_reg, q_next;

    always_comb begin
        q_next = q_reg;
        q_next.line = {pif.line_dp, pif.line_dm};
        q_next.jk = (q_reg.line == LINE_J) && ({pif.line_dp, pif.line_dm} == LINE_K);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign pif.line_state = q_reg.line;
    assign pif.j_to_k = q_reg.jk;
endmodule
`default_nettype wire

// ===== uspc_timer.sv
// Down counter that pulses done when a loaded interval has run out
`timescale 1ns/1ns
`default_nettype none
module uspc_timer #(
    parameter int TW = 20
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Load and done
    uspc_port_if.tmr pif
);
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic run;
        logic done;
    } uspc_tmr_s;
    uspc_tmr_s q_reg, q_next;

    always_comb begin
        q_next = q_reg;
        q_next.done = 1'b0;
        if (pif.tmr_load) begin
            q_next.cnt = pif.tmr_val;
            q_next.run = 1'b1;
        end else if (q_reg.run) begin
            if (q_reg.cnt <= TW'(1)) begin
                q_next.run = 1'b0;
                q_next.done = 1'b1;
            end else begin
                q_next.cnt = q_reg.cnt - TW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign pif.tmr_done = q_reg.done;
endmodule
`default_nettype wire

// ===== uspc_usb_dev.sv
// Behavioural model of the device attached to the downstream port
`timescale 1ns/1ns
`default_nettype none
module uspc_usb_dev (
    // Clock
    input wire logic sys_clk,
    // Bench commands
    input wire logic attach,
    input wire logic hs_capable,
    input wire logic wake,
    // Host drive
    input wire logic drive_bus_reset,
    input wire logic drive_resume_k,
    // Port sensing
    output logic line_dp,
    output logic line_dm,
    output logic connect_in,
    output logic hs_detected
);
    initial begin
        line_dp = 1'b0;
        line_dm = 1'b0;
        connect_in = 1'b0;
        hs_detected = 1'b0;
    end
    always @(posedge sys_clk) begin
        connect_in <= attach;
        // Host pull-downs leave SE0 on an empty port; the host reset drive wins over the device
        if (!attach || drive_bus_reset) begin
            {line_dp, line_dm} <= 2'h0;
        end else if (wake || drive_resume_k) begin
            {line_dp, line_dm} <= 2'h1;
        end else begin
            {line_dp, line_dm} <= 2'h2;
        end
        // Chirp answered only while the host holds the bus in reset
        hs_detected <= attach & hs_capable & drive_bus_reset;
    end
endmodule
`default_nettype wire

// ===== uspc_port_ctl_tb_top.sv
// Self-checking testbench for the root hub port status and control block
`timescale 1ns/1ns
`default_nettype none
module uspc_port_ctl_tb_top;
    import uspc_pkg::*;
    localparam int SC = 8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic cfg = 1'b0, halted = 1'b0, capable = 1'b1, oc = 1'b0, perr = 1'b0, busy = 1'b0;
    logic attach = 1'b0, wake = 1'b0;
    logic dp, dm, conn, hs, pcd, pwr, owns, bus_rst, res_k, dn_en;
    logic [31:0] rd_val;
    int err_count = 0;
    int total_checks = 0;
    int pcd_seen = 0;

    always #2 sys_clk = ~sys_clk;

    uspc_port_ctl #(.SETTLE_CYCLES(SC)) u_uspc_port_ctl (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .global_configured_flag(cfg), .controller_halted(halted),
        .power_control_capable(capable), .port_change_detect(pcd),
        .line_dp(dp), .line_dm(dm), .connect_in(conn), .overcurrent_in(oc),
        .hs_detected(hs), .port_error_eof2(perr), .transaction_busy(busy),
        .port_power_out(pwr), .companion_owns(owns), .drive_bus_reset(bus_rst),
        .drive_resume_k(res_k), .downstream_enable(dn_en));

    uspc_usb_dev u_uspc_usb_dev (
        .sys_clk(sys_clk), .attach(attach), .hs_capable(1'b1), .wake(wake),
        .drive_bus_reset(bus_rst), .drive_resume_k(res_k),
        .line_dp(dp), .line_dm(dm), .connect_in(conn), .hs_detected(hs));

    // One-cycle pulse, so it is counted at every edge
    always @(posedge sys_clk) begin
        if (pcd === 1'b1) begin
            pcd_seen++;
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= PSC_OFS;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic rdc(input string name, input logic [31:0] mask, input logic [31:0] exp);
        rd(PSC_OFS);
        chk(name, exp, rd_val & mask);
    endtask

    // Bounded wait for a register state; running out ends the run
    task automatic poll(input string name, input logic [31:0] mask, input logic [31:0] exp,
                        input int n);
        for (int i = 0; i < n; i++) begin
            rd(PSC_OFS);
            if ((rd_val & mask) === exp) begin
                chk(name, exp, rd_val & mask);
                return;
            end
        end
        chk(name, exp, rd_val & mask);
        report_and_stop();
    endtask

    task automatic resume_end();
        wr(32'h0000_1004);
        chk("k released", 32'h0, {31'h0, res_k});
        rdc("resume pending", 32'h40, 32'h40);
        poll("resume done", 32'hc4, 32'h04, SC / 2 + 3);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc("reset value", 32'hffff_ffff, PSC_RESET);
        rd(8'h04);
        chk("unmapped read", 32'h0, rd_val);
        attach <= 1'b1;
        wr(32'h0000_2000);
        rdc("unpowered", 32'h0000_31ff, 32'h0000_2000);
        cfg <= 1'b1;
        poll("owner cleared", 32'h2000, 32'h0, 4);
        wr(32'h0000_1004);
        poll("powered attach", 32'hffff_ffff, 32'h0000_1803, 4);
        chk("power pin", 32'h1, {31'h0, pwr});
        wr(32'h0000_1000);
        rdc("change kept", 32'h3, 32'h3);
        attach <= 1'b0;
        poll("detach", 32'h3, 32'h2, 4);
        attach <= 1'b1;
        poll("reattach", 32'h3, 32'h3, 4);
        wr(32'h0000_1002);
        rdc("change cleared", 32'h3, 32'h1);
        wr(32'h0000_1100);
        chk("reset drive", 32'h1, {31'h0, bus_rst});
        rdc("in reset", 32'h104, 32'h100);
        halted <= 1'b1;
        wr(32'h0000_1000);
        rdc("reset held", 32'h104, 32'h100);
        halted <= 1'b0;
        poll("reset done", 32'h104, 32'h004, SC / 2 + 3);
        chk("enabled pin", 32'h1, {31'h0, dn_en});
        busy <= 1'b1;
        wr(32'h0000_1084);
        rdc("suspend waits", 32'hc4, 32'h04);
        chk("traffic held", 32'h0, {31'h0, dn_en});
        busy <= 1'b0;
        poll("suspended", 32'hc4, 32'h84, 4);
        wr(32'h0000_1004);
        rdc("suspend w0", 32'hc4, 32'h84);
        wr(32'h0000_10c4);
        chk("resume k", 32'h1, {31'h0, res_k});
        rdc("sw resume", 32'hc4, 32'hc4);
        chk("no change detect", 32'h0, pcd_seen);
        resume_end();
        wr(32'h0000_1084);
        poll("suspend again", 32'hc4, 32'h84, 4);
        wake <= 1'b1;
        poll("remote wake", 32'hc4, 32'hc4, 4);
        wake <= 1'b0;
        chk("change detect", 32'h1, pcd_seen);
        resume_end();
        @(posedge sys_clk);
        perr <= 1'b1;
        @(posedge sys_clk);
        perr <= 1'b0;
        poll("port error", 32'hc, 32'h8, 4);
        chk("blocked", 32'h0, {31'h0, dn_en});
        wr(32'h0000_1000);
        rdc("error flag kept", 32'h8, 32'h8);
        wr(32'h0000_1008);
        rdc("error flag cleared", 32'h8, 32'h0);
        capable <= 1'b0;
        oc <= 1'b1;
        poll("oc active", 32'h1030, 32'h1030, 4);
        wr(32'h0000_1020);
        rdc("oc change cleared", 32'h1030, 32'h1010);
        oc <= 1'b0;
        poll("oc removed", 32'h1030, 32'h1020, 4);
        wr(32'h0000_1020);
        capable <= 1'b1;
        oc <= 1'b1;
        poll("oc power drop", 32'h1010, 32'h0010, 4);
        chk("power pin off", 32'h0, {31'h0, pwr});
        rdc("unpowered bits", 32'h1cf, 32'h0);
        wr(32'h0000_2000);
        rdc("owner handed", 32'h2000, 32'h2000);
        chk("companion pin", 32'h1, {31'h0, owns});
        cfg <= 1'b0;
        poll("owner forced", 32'h2000, 32'h2000, 4);
        cfg <= 1'b1;
        poll("owner reclaimed", 32'h2000, 32'h0, 4);
        report_and_stop();
    end
endmodule
`default_nettype wire
